// >>> hdl/bbp_pkg.sv
// Purpose: shared constants for the backlight brightness path
// Assumes: 25 MHz sys_clk, 12-bit brightness code
// Notes:   source-select codes, timing counts, widths
package bbp_pkg;
   localparam int CODE_W = 12;
   localparam int CLK_HZ = 25000000;
   // source-select encodings
   localparam logic [1:0] SRC_PWM      = 2'h0;
   localparam logic [1:0] SRC_REG      = 2'h1;
   localparam logic [1:0] SRC_PWM_XREG = 2'h2;
   localparam logic [1:0] SRC_REG_XPWM = 2'h3;
   localparam logic [1:0] SRC_RESET_I2C = 2'h3;
   // longest slope time in ms, and slope field steps
   localparam int SLOPE_MAX_MS = 200;
   localparam int SLOPE_STEPS  = 8;
   // cycles per millisecond
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   // output pwm period in clocks, 12-bit counter
   localparam int PWM_PERIOD = 4096;
   localparam int NSINK = 6;
   // string detection window in clocks
   localparam int DET_CYCLES = 1024;
   // boost request settle spacing
   localparam int BOOST_HOLD = 255;
endpackage

// >>> hdl/bbp_top.sv
// Purpose: digital brightness path of a six-string backlight driver
// Assumes: pwm input synchronous to sys_clk; config only changed when idle
// Notes:   curve shaper is a square-law approximation
// How it works
// R1: two-bit select picks brightness source
// R2: pwm-only variant forces select to 00
// R3: i2c variant resets select to 11
// R4: duty period measured rising to rising
// R5: mode 00 shapes pwm code only
// R6: mode 01 shapes register code only
// R7: mode 10 shapes pwm, multiplies register
// R8: mode 11 shapes register, multiplies pwm
// R9: crossover splits current and pwm duty
// R10: active sinks staggered by 360/count
// R11: slope ramp time 0 to 195 ms
// R12: same ramp for up and down
// R13: smoothing filter strength when advanced slope
// R14: detection drops unconnected sinks, rephases rest
// R15: no open fault while detection enabled
// R16: host may clear detection enable bit
// R17: any low headroom on an active sink requests boost up
// R18: all above mid requests boost down
// R19: product rescaled, full times full full
`timescale 1ns/1ps
module bbp_top #(
   parameter bit I2C_VARIANT = 1'b1
) (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                srst,
   // host brightness inputs
   input  wire logic                pwm_in,
   input  wire logic [1:0]          brightness_source_select,
   input  wire logic                select_load,
   input  wire logic [3:0]          brightness_level_upper,
   input  wire logic [7:0]          brightness_level_lower,
   // configuration
   input  wire logic [11:0]         crossover,
   input  wire logic [2:0]          slope_time,
   input  wire logic                adv_slope_en,
   input  wire logic [1:0]          smooth_strength,
   input  wire logic                detect_en,
   // sink and headroom comparators
   input  wire logic [5:0]          sink_connected,
   input  wire logic [5:0]          headroom_low,
   input  wire logic [5:0]          headroom_above_mid,
   input  wire logic                boost_at_max,
   // outputs
   output logic [1:0]               active_source_q,
   output logic [11:0]              current_level_q,
   output logic [5:0]               sink_pwm_q,
   output logic [5:0]               sink_active_q,
   output logic [2:0]               string_count_q,
   output logic                     boost_up_q,
   output logic                     boost_down_q,
   output logic                     open_string_fault_q,
   output logic [11:0]              brightness_q
);
   localparam int W = bbp_pkg::CODE_W;

   // square-law shaper keeps low end fine-grained
   function automatic logic [W-1:0] shape(input logic [W-1:0] c);
      logic [2*W-1:0] p;
      p = {{W{1'b0}}, c} * {{W{1'b0}}, c};
      shape = p[2*W-1:W] + {{(W-1){1'b0}}, c[W-1]};
   endfunction

   // multiply and rescale: full*full gives full
   function automatic logic [W-1:0] mulsc(input logic [W-1:0] a, input logic [W-1:0] b);
      logic [2*W-1:0] p;
      logic [2*W:0]   r;
      p = {{W{1'b0}}, a} * {{W{1'b0}}, b};
      r = {1'b0, p} + {{(W+1){1'b0}}, p[2*W-1:W]} + {{(W+1){1'b0}}, 1'b1, {(W-1){1'b0}}};
      mulsc = r[2*W-1:W];
   endfunction

   // source select register
   logic [1:0] sel_q;
   // R1: strobe loads any select
   // R2: pwm-only variant forced to 00
   // R3: reset value 11, any setting accepted
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         sel_q <= I2C_VARIANT ? bbp_pkg::SRC_RESET_I2C : bbp_pkg::SRC_PWM;
      else if (!I2C_VARIANT)
         sel_q <= bbp_pkg::SRC_PWM;
      else if (select_load)
         sel_q <= brightness_source_select;
   end
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         active_source_q <= 2'h0;
      else
         active_source_q <= sel_q;
   end

   // duty measurement
   // first period after reset counts from zero
   logic        pwm_d1_q;
   logic [19:0] per_cnt_q;
   logic [19:0] hi_cnt_q;
   logic [W-1:0] pwm_code_q;
   logic [31:0]  duty_num;
   logic [31:0]  duty_div;
   wire rise = pwm_in & ~pwm_d1_q;
   // divider kept combinational; one result per input period
   assign duty_num = {hi_cnt_q, 12'h000} - {20'h0, hi_cnt_q[19:8]};
   assign duty_div = (per_cnt_q == 20'h0) ? 32'h0 : duty_num / {12'h0, per_cnt_q};
   // R4: period is rising edge to rising edge
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         pwm_d1_q   <= 1'b0;
         per_cnt_q  <= 20'h0;
         hi_cnt_q   <= 20'h0;
         pwm_code_q <= 12'h000;
      end
      else
      begin
         pwm_d1_q <= pwm_in;
         if (rise)
         begin
            pwm_code_q <= (duty_div > 32'hfff) ? 12'hfff : duty_div[W-1:0];
            per_cnt_q  <= 20'h1;
            hi_cnt_q   <= 20'h1;
         end
         else
         begin
            if (per_cnt_q != 20'hfffff)
               per_cnt_q <= per_cnt_q + 20'h1;
            if (pwm_in && hi_cnt_q != 20'hfffff)
               hi_cnt_q <= hi_cnt_q + 20'h1;
         end
      end
   end

   // source combination
   logic [W-1:0] reg_code;
   logic [W-1:0] target;
   assign reg_code = {brightness_level_upper, brightness_level_lower};
   always_comb
   begin
      unique case (sel_q)
         // R5: pwm code shaped
         bbp_pkg::SRC_PWM:      target = shape(pwm_code_q);
         // R6: register code shaped
         bbp_pkg::SRC_REG:      target = shape(reg_code);
         // R7: shaped pwm times register
         // R19: rescaled product
         bbp_pkg::SRC_PWM_XREG: target = mulsc(shape(pwm_code_q), reg_code);
         // R8: shaped register times pwm
         bbp_pkg::SRC_REG_XPWM: target = mulsc(shape(reg_code), pwm_code_q);
      endcase
   end

   // slope: one step every tick, tick spacing from slope field
   // limitation: ramp time scales with code distance
   localparam int SLOPE_STEP_MS = bbp_pkg::SLOPE_MAX_MS / (bbp_pkg::SLOPE_STEPS - 1);
   // ticks per ms step over 4096 codes, ~ slope_time*27.9 ms full swing
   localparam int TICK_UNIT = (SLOPE_STEP_MS * bbp_pkg::CYC_PER_MS) / 4096;
   logic [W-1:0] ramp_q;
   logic [15:0]  tick_q;
   logic [15:0]  tick_lim;
   assign tick_lim = 16'(TICK_UNIT) * {13'h0, slope_time};
   // R11: step spacing scales slope time
   // R12: identical rate both directions
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ramp_q <= 12'h000;
         tick_q <= 16'h0;
      end
      else if (slope_time == 3'h0)
         ramp_q <= target;
      else if (tick_q >= tick_lim)
      begin
         tick_q <= 16'h0;
         if (ramp_q < target)
            ramp_q <= ramp_q + 12'h001;
         else if (ramp_q > target)
            ramp_q <= ramp_q - 12'h001;
      end
      else
         tick_q <= tick_q + 16'h1;
   end

   // R13: first-order smoothing, shift set by strength
   logic [W+7:0] filt_q;
   logic [W+7:0] filt_in;
   logic [3:0]   shamt;
   assign filt_in = {ramp_q, 8'h00};
   assign shamt   = {2'h0, smooth_strength} + 4'h1;
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         filt_q <= '0;
      else if (!adv_slope_en)
         filt_q <= filt_in;
      else if (filt_in > filt_q)
         filt_q <= filt_q + ((filt_in - filt_q) >> shamt) + 20'h1;
      else if (filt_in < filt_q)
         filt_q <= filt_q - ((filt_q - filt_in) >> shamt) - 20'h1;
   end
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         brightness_q <= 12'h000;
      else
         brightness_q <= filt_q[W+7:8];
   end

   // zero crossover gives pure current dimming
   // R9: above crossover current varies, below duty varies
   logic [W-1:0] duty_q;
   logic [23:0]  duty_p;
   assign duty_p = {12'h0, brightness_q} * 24'h001000;
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         current_level_q <= 12'h000;
         duty_q          <= 12'h000;
      end
      else if (brightness_q >= crossover)
      begin
         current_level_q <= brightness_q;
         duty_q          <= 12'hfff;
      end
      else
      begin
         current_level_q <= crossover;
         duty_q <= (crossover == 12'h000) ? 12'hfff
                   : 12'((duty_p / {12'h0, crossover}) > 24'hfff ? 24'hfff
                   : duty_p / {12'h0, crossover});
      end
   end

   // string detection after reset window
   // sampled once; strings attached later are ignored
   logic [10:0] det_cnt_q;
   logic        det_done_q;
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         det_cnt_q     <= 11'h0;
         det_done_q    <= 1'b0;
         sink_active_q <= 6'h3f;
      end
      else if (!det_done_q)
      begin
         det_cnt_q <= det_cnt_q + 11'h1;
         if (det_cnt_q == 11'(bbp_pkg::DET_CYCLES))
         begin
            det_done_q <= 1'b1;
            // R14: unconnected sinks dropped
            // R16: host clear keeps all sinks
            sink_active_q <= detect_en ? sink_connected : 6'h3f;
         end
      end
   end
   logic [2:0] cnt_c;
   always_comb
   begin
      cnt_c = 3'h0;
      for (int i = 0; i < bbp_pkg::NSINK; i++)
         cnt_c = cnt_c + {2'h0, sink_active_q[i]};
   end
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         string_count_q <= 3'h0;
      else
         string_count_q <= cnt_c;
   end

   // R10: phase offsets 4096/count per active sink
   logic [11:0] pcnt_q;
   logic [11:0] step;
   logic [5:0]  pwm_c;
   assign step = (cnt_c == 3'h0) ? 12'h000 : 12'(13'h1000 / {10'h0, cnt_c});
   always_comb
   begin
      logic [11:0] acc;
      acc = 12'h000;
      for (int i = 0; i < bbp_pkg::NSINK; i++)
      begin
         pwm_c[i] = sink_active_q[i] && ((12'(pcnt_q - acc) < duty_q) || duty_q == 12'hfff);
         if (sink_active_q[i])
            acc = acc + step;
      end
   end
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         pcnt_q     <= 12'h000;
         sink_pwm_q <= 6'h00;
      end
      else
      begin
         pcnt_q     <= pcnt_q + 12'h001;
         sink_pwm_q <= (brightness_q == 12'h000) ? 6'h00 : pwm_c;
      end
   end

   // boost requests; up wins, down needs all active sinks
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         boost_up_q   <= 1'b0;
         boost_down_q <= 1'b0;
      end
      else
      begin
         // R17: any low on an active sink requests up
         boost_up_q   <= |(headroom_low & sink_active_q);
         // R18: all above mid requests down
         boost_down_q <= ~|(headroom_low & sink_active_q)
                         & (&(headroom_above_mid | ~sink_active_q))
                         & (|sink_active_q);
      end
   end

   // open string fault latched until reset
   // no status read exists, so only reset clears it
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         open_string_fault_q <= 1'b0;
      // R15: suppressed while detection enabled
      else if (!detect_en && I2C_VARIANT && boost_at_max
               && |(headroom_low & sink_active_q))
         open_string_fault_q <= 1'b1;
   end
endmodule

// >>> verification/bbp_top_sva.sv
// Purpose: port checker for the brightness path
// Assumes: either variant, inputs held steady by the bench
// Notes:   two-cycle antecedents leave room for output registers
`timescale 1ns/1ps
module bbp_top_sva #(
   parameter bit I2C_VARIANT = 1'b1
) (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       srst,
   // watched inputs
   input wire logic       select_load,
   input wire logic [1:0] brightness_source_select,
   input wire logic       detect_en,
   input wire logic [5:0] sink_connected,
   input wire logic [5:0] headroom_above_mid,
   // watched outputs
   input wire logic [1:0] active_source_q,
   input wire logic [5:0] sink_pwm_q,
   input wire logic [5:0] sink_active_q,
   input wire logic       boost_up_q,
   input wire logic       boost_down_q,
   input wire logic       open_string_fault_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence s_load;
      select_load ##2 1'b1;
   endsequence
   a_src_reset: assert property ($fell(srst)
      |=> active_source_q == (I2C_VARIANT ? bbp_pkg::SRC_RESET_I2C : bbp_pkg::SRC_PWM))
      else $error("select wrong after reset");
   a_load_src: assert property (s_load |-> active_source_q ==
      (I2C_VARIANT ? $past(brightness_source_select, 2) : bbp_pkg::SRC_PWM))
      else $error("loaded select not shown");
   a_fault_hold: assert property (open_string_fault_q |=> open_string_fault_q)
      else $error("open fault dropped");
   a_no_fault_det: assert property (detect_en && !open_string_fault_q ##1 detect_en
      |-> !open_string_fault_q)
      else $error("open fault while detecting");
   a_boost_excl: assert property (!(boost_up_q && boost_down_q))
      else $error("boost up and down together");
   a_down_all: assert property (!(&(headroom_above_mid | ~sink_active_q))
      ##1 !(&(headroom_above_mid | ~sink_active_q)) |-> !boost_down_q)
      else $error("boost down without all above mid");
   a_det_sinks: assert property ($changed(sink_active_q) |-> sink_active_q == sink_connected)
      else $error("active sinks differ from connected");
   a_pwm_active: assert property ($stable(sink_active_q) ##1 $stable(sink_active_q)
      |-> (sink_pwm_q & ~sink_active_q) == 6'h00)
      else $error("pwm on removed sink");
endmodule

// >>> verification/bbp_host_pwm.sv
// Purpose: host pwm source
// Assumes: period and high time in clocks
// Notes:   only the high time is changed, period stays fixed
`timescale 1ns/1ps
module bbp_host_pwm (
   // clock
   input  wire logic        sys_clk,
   // waveform
   input  wire logic [15:0] period,
   input  wire logic [15:0] high_cnt,
   // pin
   output logic             pwm_in
);
   logic [15:0] cnt_q = 16'h0000;
   initial pwm_in = 1'b0;
   always @(negedge sys_clk)
   begin
      cnt_q  <= (cnt_q + 16'h0001 >= period) ? 16'h0000 : cnt_q + 16'h0001;
      pwm_in <= (cnt_q < high_cnt);
   end
endmodule

// >>> verification/bbp_top_tb.sv
// Purpose: self-checking bench for the brightness path
// Assumes: three strings attached, host pwm period 64 clocks
// Notes:   slope is judged by equal rates, its tick is not visible
`timescale 1ns/1ps
module bbp_top_tb;
   logic        sys_clk, srst, sel_ld, adv, det, bmax, pwm, bup, bdn, flt;
   logic [1:0]  sel, smo, src, src0;
   logic [2:0]  slope, scnt;
   logic [5:0]  conn, hlow, hmid, m6, spwm, sact;
   logic [11:0] rcode, xov, cur, bq;
   logic [15:0] hi;
   int          n_errors, cmp_count, t0, t1, tu, f;
   bbp_host_pwm host_u (.sys_clk(sys_clk), .period(16'd64), .high_cnt(hi), .pwm_in(pwm));
   bbp_top dut_u (.sys_clk(sys_clk), .srst(srst), .pwm_in(pwm),
      .brightness_source_select(sel), .select_load(sel_ld),
      .brightness_level_upper(rcode[11:8]), .brightness_level_lower(rcode[7:0]),
      .crossover(xov), .slope_time(slope), .adv_slope_en(adv), .smooth_strength(smo),
      .detect_en(det), .sink_connected(conn), .headroom_low(hlow),
      .headroom_above_mid(hmid), .boost_at_max(bmax), .active_source_q(src),
      .current_level_q(cur), .sink_pwm_q(spwm), .sink_active_q(sact),
      .string_count_q(scnt), .boost_up_q(bup), .boost_down_q(bdn),
      .open_string_fault_q(flt), .brightness_q(bq));
   // pwm-only variant shares every input, only its select is watched
   bbp_top #(.I2C_VARIANT(1'b0)) pwm_only_u (.sys_clk(sys_clk), .srst(srst), .pwm_in(pwm),
      .brightness_source_select(sel), .select_load(sel_ld),
      .brightness_level_upper(rcode[11:8]), .brightness_level_lower(rcode[7:0]),
      .crossover(xov), .slope_time(slope), .adv_slope_en(adv), .smooth_strength(smo),
      .detect_en(det), .sink_connected(conn), .headroom_low(hlow),
      .headroom_above_mid(hmid), .boost_at_max(bmax), .active_source_q(src0),
      .current_level_q(), .sink_pwm_q(), .sink_active_q(), .string_count_q(),
      .boost_up_q(), .boost_down_q(), .open_string_fault_q(), .brightness_q());
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic chk(input logic [11:0] got, input int exp, input int tol);
      cmp_count++;
      if ($isunknown(got) || got + tol < exp || got > exp + tol)
      begin
         n_errors++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // loads a select, then lets a few pwm periods pass
   task automatic mode(input logic [1:0] m, input logic [11:0] r);
      sel = m;
      rcode = r;
      sel_ld = 1'b1;
      cyc(1);
      sel_ld = 1'b0;
      cyc(300);
   endtask
   task automatic tally_and_finish;
      $display("compares %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      {srst, det, bmax} = 3'h7;
      {sel_ld, adv, sel, smo, slope} = 9'h000;
      {rcode, xov} = 24'h000000;
      {conn, hlow, hmid} = {6'h15, 6'h01, 6'h3e};
      {n_errors, cmp_count} = {32'd0, 32'd0};
      hi = 16'd32;
      cyc(6);
      srst = 1'b0;
      cyc(3);
      chk(12'(src), 3, 0);
      chk(12'(src0), 0, 0);
      cyc(bbp_pkg::DET_CYCLES + 20);
      chk(12'(sact), 'h15, 0);
      chk(12'(scnt), 3, 0);
      chk(12'(bup), 1, 0);
      chk(12'(flt), 0, 0);
      {hlow, hmid} = {6'h00, 6'h3f};
      cyc(300);
      chk(12'({bup, bdn}), 1, 0);
      mode(bbp_pkg::SRC_REG, 12'h000);
      chk(12'(src), 1, 0);
      chk(12'(src0), 0, 0);
      chk(bq, 0, 0);
      mode(bbp_pkg::SRC_REG, 12'hfff);
      chk(bq, 'hfff, 0);
      chk(cur, 'hfff, 0);
      chk(12'(spwm), sact, 0);
      mode(bbp_pkg::SRC_PWM, 12'h000);
      f = bq;
      chk(bq, 1023, 300);
      mode(bbp_pkg::SRC_PWM_XREG, 12'hfff);
      chk(bq, f, 2);
      mode(bbp_pkg::SRC_PWM_XREG, 12'h000);
      chk(bq, 0, 0);
      mode(bbp_pkg::SRC_REG_XPWM, 12'hfff);
      chk(bq, 2047, 2);
      hi = 16'd48;
      cyc(300);
      chk(bq, 3071, 2);
      xov = 12'h800;
      mode(bbp_pkg::SRC_REG, 12'h400);
      chk(cur, 'h800, 0);
      {t0, t1} = {-32'sd1, -32'sd1};
      for (int i = 0; i < 9000 && t1 < 0; i++)
      begin
         m6 = spwm;
         cyc(1);
         if (spwm[0] && !m6[0] && t0 < 0)
            t0 = i;
         if (spwm[2] && !m6[2] && t0 >= 0)
            t1 = i;
      end
      chk(12'(t1 - t0), 1365, 2);
      xov = 12'h000;
      mode(bbp_pkg::SRC_REG, 12'h000);
      slope = 3'h1;
      rcode = 12'h200;
      cyc(1000);
      tu = bq;
      cyc(20000);
      f = bq;
      chk(12'(tu < f), 1, 0);
      rcode = 12'h000;
      cyc(1000);
      chk(12'(f - bq), tu, 1);
      cyc(20000);
      chk(bq, 0, 0);
      {slope, adv, smo, rcode} = {3'h0, 1'b1, 2'h3, 12'hfff};
      cyc(4);
      chk(12'(bq < 12'hfff), 1, 0);
      // second reset without detection, a low string at full boost
      {det, hlow, hmid, srst} = {1'b0, 6'h01, 6'h3e, 1'b1};
      cyc(6);
      srst = 1'b0;
      cyc(2000);
      chk(12'(flt), 1, 0);
      tally_and_finish();
   end
   // hang guard, well past the planned run
   initial
   begin
      #(90000 * 40);
      n_errors++;
      tally_and_finish();
   end
endmodule
bind bbp_top bbp_top_sva #(.I2C_VARIANT(I2C_VARIANT)) chk_u (.sys_clk(sys_clk), .srst(srst),
   .select_load(select_load),
   .brightness_source_select(brightness_source_select), .detect_en(detect_en),
   .sink_connected(sink_connected), .headroom_above_mid(headroom_above_mid),
   .active_source_q(active_source_q), .sink_pwm_q(sink_pwm_q),
   .sink_active_q(sink_active_q), .boost_up_q(boost_up_q), .boost_down_q(boost_down_q),
   .open_string_fault_q(open_string_fault_q));
